// file: bfs_pkg.sv
// Package: constants, map and carrier types of the buck fault supervisor
package bfs_pkg;

  // Clock and timing
  localparam int CLK_HZ = 25_000_000;             // System clock rate
  localparam int DEFAULT_FSW_KHZ = 450;           // Switching rate with frequency_set_pin open
  localparam int DEFAULT_OSC_DIV = CLK_HZ / (DEFAULT_FSW_KHZ * 1000); // Clocks per switching cycle
  localparam int SYNC_LOCK_EDGES = 16;            // External edges before hand-over
  localparam int HICCUP_CYCLES = 32768;           // Switching cycles of hiccup pause
  localparam int PGOOD_DELAY_CYCLES = 1024;       // Switching cycles before power-good release
  localparam int SYNC_LOSS_MULT = 2;              // Missing-edge window in internal periods

  // Register map, byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;        // Enable
  localparam logic [7:0] OFF_FREQ = 8'h04;        // Programmed oscillator divider
  localparam logic [7:0] OFF_STATUS = 8'h08;      // Live state
  localparam logic [7:0] OFF_FAULT = 8'h0c;       // Sticky faults, write one to clear

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int FAULT_SHORT_BIT = 0;
  localparam int FAULT_RUNAWAY_BIT = 1;
  localparam int FAULT_UV_BIT = 2;
  localparam int FAULT_THERM_BIT = 3;
  localparam int STATUS_MODE_LSB = 8;
  localparam int STATUS_PG_BIT = 12;
  localparam int STATUS_EXT_BIT = 13;
  localparam int STATUS_LIMLO_BIT = 14;
  localparam int STATUS_LATCH_BIT = 15;

  // Reset values and response codes
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic [15:0] FREQ_RST = 16'(DEFAULT_OSC_DIV);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Gate-drive resistor codes
  localparam logic [1:0] DLR_OPEN = 2'h0;         // High limits, hiccup
  localparam logic [1:0] DLR_174K = 2'h1;         // High limits, latch-off
  localparam logic [1:0] DLR_61K9 = 2'h2;         // Low limits, hiccup
  localparam logic [1:0] DLR_26K1 = 2'h3;         // Low limits, latch-off

  // Sequencer states
  typedef enum logic [6:0] {
    BFS_OFF     = 7'h01,
    BFS_SHORT   = 7'h02,
    BFS_SOFT    = 7'h04,
    BFS_RUN     = 7'h08,
    BFS_HICCUP  = 7'h10,
    BFS_LATCHED = 7'h20,
    BFS_THERMAL = 7'h40
  } bfs_state_e_t;

  // Light-load modes
  typedef enum logic [2:0] {
    BFS_MODE_SKIP = 3'h1,                         // pulse_skip_mode
    BFS_MODE_PWM  = 3'h2,
    BFS_MODE_NNC  = 3'h4                          // no_negative_current_mode
  } bfs_mode_t;

  // Comparator and pin inputs from the power stage
  typedef struct packed {
    logic uvlo_ok;        // Supplies and enable above lockout
    logic dl_short;       // low_side_gate_drive shorted to switch_node
    logic fset_open;      // frequency_set_pin unconnected
    logic mode_gnd;       // Mode/sync pin at signal_ground
    logic mode_vcc;       // Mode/sync pin at internal supply
    logic sync_in;        // Mode/sync pin logic level
    logic hs_peak;        // High-side current above peak limit
    logic hs_runaway;     // High-side current above runaway limit
    logic vout_lt68;      // Output below 68 percent
    logic vout_gt955;     // Output above 95.5 percent
    logic vout_lt925;     // Output below 92.5 percent
    logic ss_done;        // Soft-start ramp finished
    logic temp_hot;       // Junction above shutdown point
    logic temp_cool;      // Junction fallen by the hysteresis
    logic pwm_req;        // Modulator requests a high-side pulse
    logic [1:0] dl_res;   // Gate-drive resistor code
  } bfs_ana_t;

  // Drive outputs to the power stage
  typedef struct packed {
    logic hs_gate;        // High-side switch on
    logic ls_gate;        // Low-side switch on
    logic ss_run;         // Soft-start ramp enabled
    logic limit_low;      // Lower current limit pair selected
    logic osc_ext;        // Oscillator follows external clock
    bfs_mode_t mode;      // Active light-load mode
    logic pg_out;         // Power-good pin output value
    logic pg_oe;          // Power-good output enable, low drives pin
  } bfs_drv_t;

  // Whole module state
  typedef struct packed {
    bfs_ana_t s1;
    bfs_ana_t s2;
    bfs_ana_t s3;
    bfs_ana_t in;         // Filtered inputs
    bfs_state_e_t st;
    bfs_mode_t mode;
    logic forced_pwm;
    logic latch_mode;
    logic limit_low;
    logic started;
    logic ext_lock;
    logic [4:0] sync_edges;
    logic [16:0] sync_gap;
    logic [15:0] osc_cnt;
    logic [15:0] hic_cnt;
    logic [10:0] pg_cnt;
    logic pg;
    logic ctrl_en;
    logic [15:0] osc_div;
    logic [3:0] fault;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    bfs_drv_t drv;
  } bfs_state_t;

endpackage

// file: bfs_supervisor.sv
// Sequencing, fault and power-good supervisor with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none

// Function
// - Switch to external clock after 16 edges
// - External clock forces fixed-frequency PWM mode
// - Clock removed: internal rate, stay PWM
// - Open frequency pin gives 450kHz default
// - Gate-to-switch short blocks startup entirely
// - Peak current ends high-side pulse each cycle
// - One runaway detection triggers overload response
// - Output below 68% after soft-start faults
// - Hiccup pauses 32768 cycles then retries
// - Latch-off stays off until power cycle
// - Gate-drive resistor picks limits and response
// - Power-good releases 1024 cycles after 95.5%
// - Power-good low below 92.5%
// - Power-good low during thermal shutdown
// - Prebias: switches off until first pulse
// - Thermal shutdown, restart soft-start after cooling
// - Floating mode pin reads as no clock
// - Mode pin latched once at lockout release
module bfs_supervisor #(
  parameter int HICCUP_CYCLES = bfs_pkg::HICCUP_CYCLES,
  parameter int PGOOD_DELAY = bfs_pkg::PGOOD_DELAY_CYCLES,
  parameter int SYNC_EDGES = bfs_pkg::SYNC_LOCK_EDGES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire bfs_pkg::bfs_ana_t ana_in,
  output var bfs_pkg::bfs_drv_t drv_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Register word index; 4 means unmapped
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    case (addr)
      bfs_pkg::OFF_CTRL: reg_sel = 3'h0;
      bfs_pkg::OFF_FREQ: reg_sel = 3'h1;
      bfs_pkg::OFF_STATUS: reg_sel = 3'h2;
      bfs_pkg::OFF_FAULT: reg_sel = 3'h3;
      default: reg_sel = 3'h4;
    endcase
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  localparam logic [15:0] HIC_LAST = 16'(HICCUP_CYCLES - 1);   // Last hiccup cycle
  localparam logic [10:0] PG_LAST = 11'(PGOOD_DELAY - 1);      // Last power-good delay cycle
  localparam logic [4:0] EDGE_LAST = 5'(SYNC_EDGES - 1);       // Last edge before lock
  localparam logic [15:0] DIV_DEFAULT = 16'(bfs_pkg::DEFAULT_OSC_DIV);

  bfs_pkg::bfs_state_t q_r;   // Whole state
  bfs_pkg::bfs_state_t q_nxt; // Next state

  logic sync_rise;            // Filtered external clock edge
  logic tick;                 // One switching cycle elapsed
  logic [15:0] div_now;       // Active internal divider
  logic [16:0] gap_limit;     // Missing-edge window
  logic active;               // Soft-start or running
  logic fault_evt;            // Overload response request
  logic [31:0] status;        // Status word
  logic [31:0] wword;         // Merged write word
  logic [3:0] fset;           // Fault flags set this cycle
  logic [3:0] fclr;           // Fault flags cleared by software
  logic wr_go;                // Write executes this cycle
  logic [31:0] rd_word;       // Read mux

  // All next-state logic
  always_comb begin
    q_nxt = q_r;
    fset = 4'h0;
    fclr = 4'h0;
    wword = 32'h0;
    rd_word = 32'h0;

    // Three-stage sampling; a change counts when stages two and three agree
    q_nxt.s1 = ana_in;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    for (int b = 0; b < $bits(bfs_pkg::bfs_ana_t); b++) begin
      if (q_r.s2[b] == q_r.s3[b]) begin
        q_nxt.in[b] = q_r.s3[b];
      end
    end

    // Resistor divider unless pin open
    div_now = q_r.in.fset_open ? DIV_DEFAULT : q_r.osc_div;
    gap_limit = 17'(div_now) * 17'(bfs_pkg::SYNC_LOSS_MULT);

    // External clock edge: pull-down keeps a floating pin low, so no edges
    sync_rise = q_nxt.in.sync_in & ~q_r.in.sync_in;

    // Edge counting and loss detection on the mode/sync pin
    if (sync_rise) begin
      q_nxt.sync_gap = 17'h0;
      if (!q_r.ext_lock) begin
        if (q_r.sync_edges == EDGE_LAST) begin
          q_nxt.ext_lock = 1'b1;
          q_nxt.forced_pwm = 1'b1;
        end else begin
          q_nxt.sync_edges = q_r.sync_edges + 5'h1;
        end
      end
    end else if (q_r.sync_gap >= gap_limit) begin
      // Clock gone: back to internal rate, PWM stays sticky
      q_nxt.ext_lock = 1'b0;
      q_nxt.sync_edges = 5'h0;
    end else begin
      q_nxt.sync_gap = q_r.sync_gap + 17'h1;
    end

    // Switching cycle tick from the active oscillator
    tick = 1'b0;
    if (q_r.ext_lock) begin
      tick = sync_rise;
      q_nxt.osc_cnt = 16'h0;
    end else if (q_r.osc_cnt >= div_now - 16'h1) begin
      tick = 1'b1;
      q_nxt.osc_cnt = 16'h0;
    end else begin
      q_nxt.osc_cnt = q_r.osc_cnt + 16'h1;
    end

    active = (q_r.st == bfs_pkg::BFS_SOFT) || (q_r.st == bfs_pkg::BFS_RUN);
    fault_evt = active && q_r.in.hs_runaway;
    if (q_r.st == bfs_pkg::BFS_RUN && q_r.in.vout_lt68) begin
      fault_evt = 1'b1;
    end

    // Sequencer
    case (q_r.st)
      bfs_pkg::BFS_OFF: begin
        q_nxt.hic_cnt = 16'h0;
        if (q_r.in.uvlo_ok && q_r.ctrl_en) begin
          // Mode pin and gate-drive resistor sampled once here
          if (q_r.in.mode_gnd) begin
            q_nxt.mode = bfs_pkg::BFS_MODE_PWM;
          end else if (q_r.in.mode_vcc) begin
            q_nxt.mode = bfs_pkg::BFS_MODE_NNC;
          end else begin
            q_nxt.mode = bfs_pkg::BFS_MODE_SKIP;
          end
          q_nxt.latch_mode = (q_r.in.dl_res == bfs_pkg::DLR_174K) || (q_r.in.dl_res == bfs_pkg::DLR_26K1);
          q_nxt.limit_low = (q_r.in.dl_res == bfs_pkg::DLR_61K9) || (q_r.in.dl_res == bfs_pkg::DLR_26K1);
          if (q_r.in.dl_short) begin
            q_nxt.st = bfs_pkg::BFS_SHORT;
            fset[bfs_pkg::FAULT_SHORT_BIT] = 1'b1;
          end else if (q_r.in.temp_hot) begin
            q_nxt.st = bfs_pkg::BFS_THERMAL;
          end else begin
            q_nxt.st = bfs_pkg::BFS_SOFT;
          end
        end
      end
      bfs_pkg::BFS_SHORT: begin
        // No soft-start while the short stands
        if (!q_r.in.uvlo_ok || !q_r.ctrl_en) begin
          q_nxt.st = bfs_pkg::BFS_OFF;
        end
      end
      bfs_pkg::BFS_SOFT, bfs_pkg::BFS_RUN: begin
        if (!q_r.in.uvlo_ok || !q_r.ctrl_en) begin
          q_nxt.st = bfs_pkg::BFS_OFF;
        end else if (q_r.in.temp_hot) begin
          q_nxt.st = bfs_pkg::BFS_THERMAL;
          fset[bfs_pkg::FAULT_THERM_BIT] = 1'b1;
        end else if (fault_evt) begin
          q_nxt.hic_cnt = 16'h0;
          q_nxt.st = q_r.latch_mode ? bfs_pkg::BFS_LATCHED : bfs_pkg::BFS_HICCUP;
          fset[bfs_pkg::FAULT_RUNAWAY_BIT] = q_r.in.hs_runaway;
          fset[bfs_pkg::FAULT_UV_BIT] = ~q_r.in.hs_runaway;
        end else if (q_r.st == bfs_pkg::BFS_SOFT && q_r.in.ss_done) begin
          q_nxt.st = bfs_pkg::BFS_RUN;
        end
      end
      bfs_pkg::BFS_HICCUP: begin
        // Counts active-oscillator cycles, then retries soft-start
        if (!q_r.in.uvlo_ok || !q_r.ctrl_en) begin
          q_nxt.st = bfs_pkg::BFS_OFF;
        end else if (tick) begin
          if (q_r.hic_cnt == HIC_LAST) begin
            q_nxt.st = bfs_pkg::BFS_SOFT;
            q_nxt.hic_cnt = 16'h0;
          end else begin
            q_nxt.hic_cnt = q_r.hic_cnt + 16'h1;
          end
        end
      end
      bfs_pkg::BFS_LATCHED: begin
        // Only a reset, the supply cycle, leaves here
        q_nxt.st = bfs_pkg::BFS_LATCHED;
      end
      bfs_pkg::BFS_THERMAL: begin
        if (!q_r.in.uvlo_ok || !q_r.ctrl_en) begin
          q_nxt.st = bfs_pkg::BFS_OFF;
        end else if (q_r.in.temp_cool && !q_r.in.temp_hot) begin
          q_nxt.st = bfs_pkg::BFS_SOFT;
        end
      end
      default: begin
        q_nxt.st = bfs_pkg::BFS_OFF;
      end
    endcase

    // Prebias: no switching until the first modulator pulse request
    if (!active || q_nxt.st != q_r.st) begin
      q_nxt.started = 1'b0;
    end else if (q_r.in.pwm_req) begin
      q_nxt.started = 1'b1;
    end

    // Power-good delay and drop
    if (q_r.in.vout_lt925 || q_r.in.temp_hot || q_r.st == bfs_pkg::BFS_THERMAL) begin
      q_nxt.pg = 1'b0;
      q_nxt.pg_cnt = 11'h0;
    end else if (!q_r.in.vout_gt955) begin
      q_nxt.pg_cnt = 11'h0;
    end else if (!q_r.pg && tick) begin
      if (q_r.pg_cnt == PG_LAST) begin
        q_nxt.pg = 1'b1;
      end else begin
        q_nxt.pg_cnt = q_r.pg_cnt + 11'h1;
      end
    end

    // Gate drives; peak limit cuts the high-side pulse at once
    q_nxt.drv.hs_gate = active && q_nxt.started && q_r.in.pwm_req && !q_r.in.hs_peak
                        && !fault_evt && q_nxt.st == q_r.st;
    q_nxt.drv.ls_gate = active && q_nxt.started && !q_r.in.pwm_req && q_nxt.st == q_r.st;
    q_nxt.drv.ss_run = (q_nxt.st == bfs_pkg::BFS_SOFT) || (q_nxt.st == bfs_pkg::BFS_RUN);
    q_nxt.drv.limit_low = q_nxt.limit_low;
    q_nxt.drv.osc_ext = q_nxt.ext_lock;
    q_nxt.drv.mode = q_nxt.forced_pwm ? bfs_pkg::BFS_MODE_PWM : q_nxt.mode;
    q_nxt.drv.pg_out = 1'b0;
    q_nxt.drv.pg_oe = q_nxt.pg;

    // Status word
    status = 32'h0;
    status[6:0] = q_r.st;
    status[bfs_pkg::STATUS_MODE_LSB +: 3] = q_r.drv.mode;
    status[bfs_pkg::STATUS_PG_BIT] = q_r.pg;
    status[bfs_pkg::STATUS_EXT_BIT] = q_r.ext_lock;
    status[bfs_pkg::STATUS_LIMLO_BIT] = q_r.limit_low;
    status[bfs_pkg::STATUS_LATCH_BIT] = q_r.latch_mode;

    // Write address and data taken in either order
    if (s_axi_awvalid && q_r.awready) begin
      q_nxt.aw_got = 1'b1;
      q_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_r.wready) begin
      q_nxt.w_got = 1'b1;
      q_nxt.wdata = s_axi_wdata;
      q_nxt.wstrb = s_axi_wstrb;
    end
    wr_go = q_r.aw_got && q_r.w_got && !q_r.bvalid;
    if (wr_go) begin
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = bfs_pkg::RESP_OKAY;
      case (reg_sel(q_r.awaddr))
        3'h0: begin
          wword = merge({31'h0, q_r.ctrl_en}, q_r.wdata, q_r.wstrb);
          q_nxt.ctrl_en = wword[bfs_pkg::CTRL_EN_BIT];
        end
        3'h1: begin
          wword = merge({16'h0, q_r.osc_div}, q_r.wdata, q_r.wstrb);
          q_nxt.osc_div = (wword[15:0] == 16'h0) ? 16'h1 : wword[15:0];
        end
        3'h2: begin
          wword = 32'h0;
        end
        3'h3: begin
          wword = merge(32'h0, q_r.wdata, q_r.wstrb);
          fclr = wword[3:0];
        end
        default: begin
          q_nxt.bresp = bfs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
    end
    q_nxt.awready = !q_nxt.aw_got && !q_nxt.bvalid;
    q_nxt.wready = !q_nxt.w_got && !q_nxt.bvalid;

    // Sticky faults: a set in the clearing cycle wins
    q_nxt.fault = (q_r.fault & ~fclr) | fset;

    // Read channel, one outstanding
    if (s_axi_arvalid && q_r.arready) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = bfs_pkg::RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        3'h0: rd_word = {31'h0, q_r.ctrl_en};
        3'h1: rd_word = {16'h0, q_r.osc_div};
        3'h2: rd_word = status;
        3'h3: rd_word = {28'h0, q_r.fault};
        default: begin
          rd_word = 32'h0;
          q_nxt.rresp = bfs_pkg::RESP_SLVERR;
        end
      endcase
      q_nxt.rdata = rd_word;
    end else if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
    end
    q_nxt.arready = !q_nxt.rvalid;
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
      q_r.st <= bfs_pkg::BFS_OFF;
      q_r.mode <= bfs_pkg::BFS_MODE_SKIP;
      q_r.drv.mode <= bfs_pkg::BFS_MODE_SKIP;
      q_r.ctrl_en <= bfs_pkg::CTRL_EN_RST;
      q_r.osc_div <= bfs_pkg::FREQ_RST;
      q_r.awready <= 1'b1;
      q_r.wready <= 1'b1;
      q_r.arready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from the state flops
  assign drv_out = q_r.drv;
  assign s_axi_awready = q_r.awready;
  assign s_axi_wready = q_r.wready;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_arready = q_r.arready;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rdata = q_r.rdata;
  assign s_axi_rresp = q_r.rresp;

endmodule

`default_nettype wire

// file: bfs_supervisor_properties.sv
// Concurrent checks on the supervisor ports
`timescale 1ns/1ns
`default_nettype none
module bfs_props #(
  parameter int PGOOD_DELAY = 8,
  parameter int SYNC_EDGES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire bfs_pkg::bfs_ana_t ana_in,
  input wire bfs_pkg::bfs_drv_t drv_out,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  localparam int TMIN = 40; // Shortest switching period, clocks
  logic [15:0] hi_n; // Clocks with output above 95.5 percent
  logic [7:0] edg_n; // Sync edges while unlocked
  logic seen_req; // Modulator has asked for a pulse
  logic sync_q; // Last sync level
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Helper counts; raw inputs lead the filtered ones, so bounds stay safe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_n <= 16'h0;
      edg_n <= 8'h0;
      seen_req <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      hi_n <= !ana_in.vout_gt955 ? 16'h0 : hi_n + 16'(hi_n != 16'hffff);
      edg_n <= drv_out.osc_ext ? 8'h0 : edg_n + 8'(ana_in.sync_in && !sync_q);
      seen_req <= seen_req || ana_in.pwm_req;
      sync_q <= ana_in.sync_in;
    end
  end
  short_hold_a: assert property ((ana_in.dl_short && !drv_out.ss_run) [*8] |=> !drv_out.ss_run)
    else $error("soft-start began with gate short present");
  peak_cut_a: assert property (ana_in.hs_peak [*6] |-> !drv_out.hs_gate)
    else $error("high side on above peak limit");
  runaway_stop_a: assert property (ana_in.hs_runaway [*7] |-> !drv_out.hs_gate && !drv_out.ls_gate)
    else $error("switching continued after runaway");
  pg_hot_a: assert property (ana_in.temp_hot [*7] |-> !drv_out.pg_oe)
    else $error("power-good released while hot");
  pg_low_a: assert property (ana_in.vout_lt925 [*7] |-> !drv_out.pg_oe)
    else $error("power-good released below 92.5 percent");
  pg_wait_a: assert property ($rose(drv_out.pg_oe) |-> hi_n >= 16'((PGOOD_DELAY - 1) * TMIN))
    else $error("power-good released early");
  prebias_off_a: assert property (!seen_req |-> !drv_out.hs_gate && !drv_out.ls_gate)
    else $error("switching before first pulse request");
  ext_pwm_a: assert property (drv_out.osc_ext [*2] |-> drv_out.mode == bfs_pkg::BFS_MODE_PWM)
    else $error("external clock without fixed PWM");
  lock_edges_a: assert property ($rose(drv_out.osc_ext) |-> edg_n >= 8'(SYNC_EDGES))
    else $error("locked before enough sync edges");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cover property ($rose(drv_out.osc_ext));
  cover property ($rose(drv_out.pg_oe));
  cover property ($fell(drv_out.ss_run));
endmodule
`default_nettype wire

// file: bfs_stage_model.sv
// Behavioural power stage: levels, sync clock, peak sensing
`timescale 1ns/1ns
`default_nettype none
module bfs_stage_model #(
  parameter int ON_T = 3 // Gate clocks until peak current
) (
  input wire logic aclk,
  input wire bfs_pkg::bfs_ana_t cmd,
  input wire logic sync_on,
  input wire bfs_pkg::bfs_drv_t drv,
  output var bfs_pkg::bfs_ana_t ana
);
  logic [5:0] ph = 6'h00; // Sync clock phase
  logic [3:0] on_n = 4'h0; // High-side on time
  // Sync period 44 clocks, four fifths of the 55-clock default
  always @(posedge aclk) begin
    ph <= (!sync_on || ph == 6'h2b) ? 6'h00 : ph + 6'h01;
    on_n <= drv.hs_gate ? on_n + 4'(on_n != 4'hf) : 4'h0;
  end
  // Pin idles low through the pull-down when no clock
  always_comb begin
    ana = cmd;
    ana.sync_in = sync_on && ph >= 6'h16;
    ana.hs_peak = cmd.hs_peak || on_n >= 4'(ON_T);
  end
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the supervisor
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int DIV = 25000000 / (450 * 1000); // Default divider
  logic aclk, aresetn, sync_on;
  bfs_pkg::bfs_ana_t cm, ana; // Commanded and stage levels
  bfs_pkg::bfs_drv_t drv;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v, e;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  bfs_pkg::bfs_mode_t emode [4] = '{bfs_pkg::BFS_MODE_SKIP, bfs_pkg::BFS_MODE_PWM,
    bfs_pkg::BFS_MODE_NNC, bfs_pkg::BFS_MODE_SKIP}; // Expected latched modes
  int n_fail = 0;
  int tests_run = 0;
  int cyc_n = 0;
  bfs_stage_model #(.ON_T(3)) u_stage (.aclk(aclk), .cmd(cm), .sync_on(sync_on), .drv(drv), .ana(ana));
  bfs_supervisor #(.HICCUP_CYCLES(8), .PGOOD_DELAY(8), .SYNC_EDGES(4)) dut (.aclk(aclk),
    .aresetn(aresetn), .ana_in(ana), .drv_out(drv), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // Free-running clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Sequencer state from the status word
  task automatic st(input logic [6:0] x);
    rd(bfs_pkg::OFF_STATUS);
    chk("state", {25'h0, d[6:0]}, {25'h0, x});
  endtask
  task automatic rst();
    cm.uvlo_ok <= 1'b0;
    aresetn <= 1'b0;
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
  endtask
  initial begin
    aresetn = 1'b0;
    sync_on = 1'b0;
    cm = '0;
    cm.fset_open = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    void'($urandom(32'ha7a5));
    rst();
    rd(bfs_pkg::OFF_FREQ);
    chk("freq", d, 32'(DIV));
    v = $urandom & 32'hffff;
    e = $urandom & 32'hf;
    wr(bfs_pkg::OFF_FREQ, v, e[3:0]);
    e = {16'h0, e[1] ? v[15:8] : 8'h00, e[0] ? v[7:0] : 8'(DIV)};
    rd(bfs_pkg::OFF_FREQ);
    chk("freq_rw", d, (e == 32'h0) ? 32'h1 : e);
    wr(8'h14, 32'h0, 4'hf);
    chk("wr_resp", {30'h0, r}, {30'h0, bfs_pkg::RESP_SLVERR});
    rd(8'h10);
    chk("rd_unmapped", {d[29:0], r}, {30'h0, bfs_pkg::RESP_SLVERR});
    wr(bfs_pkg::OFF_STATUS, 32'hffffffff, 4'hf);
    st(bfs_pkg::BFS_OFF);
    wr(bfs_pkg::OFF_FREQ, 32'(DIV), 4'hf);
    $display("test registers done");
    // Short blocks startup
    cm.dl_short <= 1'b1;
    cm.uvlo_ok <= 1'b1;
    cyc(30);
    chk("ss_short", 32'(drv.ss_run), 32'h0);
    st(bfs_pkg::BFS_SHORT);
    cm.dl_short <= 1'b0;
    $display("test short done");
    // Every mode pin and gate-drive code, with a fault each time
    for (int i = 0; i < 4; i++) begin
      cm.mode_gnd <= (i == 1);
      cm.mode_vcc <= (i == 2);
      cm.dl_res <= 2'(i);
      rst();
      cm.uvlo_ok <= 1'b1;
      cyc(10);
      chk("mode", 32'(drv.mode), 32'(emode[i]));
      chk("limit", 32'(drv.limit_low), 32'(i / 2));
      cm.mode_gnd <= (i != 1);
      cm.vout_lt68 <= 1'b1;
      cyc(30);
      chk("mode_hold", 32'(drv.mode), 32'(emode[i]));
      chk("gates", {30'h0, drv.hs_gate, drv.ls_gate}, 32'h0);
      st(bfs_pkg::BFS_SOFT);
      cm.vout_lt68 <= 1'b0;
      cm.pwm_req <= 1'b1;
      cm.ss_done <= 1'b1;
      cyc($urandom_range(20, 60));
      st(bfs_pkg::BFS_RUN);
      if (i < 2) cm.vout_lt68 <= 1'b1;
      else cm.hs_runaway <= 1'b1;
      cyc(15);
      e = (i % 2) ? 32'(bfs_pkg::BFS_LATCHED) : 32'(bfs_pkg::BFS_HICCUP);
      st(e[6:0]);
      {cm.vout_lt68, cm.hs_runaway, cm.ss_done, cm.pwm_req} <= 4'h0;
      cyc(8 * DIV - 120);
      st(e[6:0]);
      cyc(200);
      st((i % 2) ? bfs_pkg::BFS_LATCHED : bfs_pkg::BFS_SOFT);
      $display("test fault %0d done", i);
    end
    // Power-good delay, drop and thermal cycle
    {cm.dl_res, cm.mode_gnd, cm.mode_vcc} <= 4'h0;
    rst();
    {cm.uvlo_ok, cm.pwm_req, cm.ss_done} <= 3'h7;
    cyc(20);
    cm.vout_gt955 <= 1'b1;
    cyc(8 * DIV - 60);
    chk("pg_early", 32'(drv.pg_oe), 32'h0);
    cyc(120);
    chk("pg_up", 32'(drv.pg_oe), 32'h1);
    {cm.vout_gt955, cm.vout_lt925} <= 2'h1;
    cyc(10);
    chk("pg_drop", 32'({drv.pg_out, drv.pg_oe}), 32'h0);
    {cm.vout_gt955, cm.vout_lt925} <= 2'h2;
    cyc(500);
    chk("pg_back", 32'(drv.pg_oe), 32'h1);
    {cm.temp_hot, cm.ss_done} <= 2'h2;
    cyc(10);
    chk("pg_hot", 32'(drv.pg_oe), 32'h0);
    st(bfs_pkg::BFS_THERMAL);
    rd(bfs_pkg::OFF_FAULT);
    chk("fault", d, 32'h1 << bfs_pkg::FAULT_THERM_BIT);
    wr(bfs_pkg::OFF_FAULT, 32'hf, 4'hf);
    rd(bfs_pkg::OFF_FAULT);
    chk("fault_clr", d, 32'h0);
    {cm.temp_hot, cm.temp_cool} <= 2'h1;
    cyc(10);
    st(bfs_pkg::BFS_SOFT);
    $display("test power_good done");
    // Sync lock, forced PWM, loss of clock
    sync_on <= 1'b1;
    cyc(100);
    chk("early_lock", 32'(drv.osc_ext), 32'h0);
    cyc(200);
    chk("lock", 32'(drv.osc_ext), 32'h1);
    chk("sync_mode", 32'(drv.mode), 32'(bfs_pkg::BFS_MODE_PWM));
    sync_on <= 1'b0;
    cyc(200);
    chk("unlock", 32'(drv.osc_ext), 32'h0);
    chk("keep_pwm", 32'(drv.mode), 32'(bfs_pkg::BFS_MODE_PWM));
    $display("test sync done");
    close_out();
  end
endmodule
bind bfs_supervisor bfs_props #(.PGOOD_DELAY(PGOOD_DELAY), .SYNC_EDGES(SYNC_EDGES)) u_props (.aclk(aclk),
  .aresetn(aresetn), .ana_in(ana_in), .drv_out(drv_out), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire
